// *** logic/doag_core.sv ***
// data operand address generator: mode decode, address forming, pointers
`timescale 1ns/10ps
module doag_core (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic extended_isa_enable_i,
  input doag_pkg::doag_instr_s instr_i,
  input wire logic [3:0] bank_select_reg_i,
  input wire logic [7:0] wreg_i,
  input wire logic ptr_wr_i,
  input wire logic [1:0] ptr_wr_sel_i,
  input wire logic ptr_wr_hi_i,
  input wire logic [7:0] ptr_wr_data_i,
  output doag_pkg::doag_result_s result_o,
  output logic [11:0] ptr0_o,
  output logic [11:0] ptr1_o,
  output logic [11:0] ptr2_o,
  output logic alias_hit_o
);
  import doag_pkg::*;

  logic [11:0] ptr_reg [3];
  logic [11:0] ptr_next [3];
  doag_result_s result_reg;
  doag_result_s result_next;
  logic alias_hit_reg;

  // access bank: low literals to bank 0, the rest to the sfr bank
  function automatic logic [11:0] access_map(input logic [7:0] lit);
    access_map = (lit < ACCESS_SPLIT) ? {LOW_BANK, lit} : {SFR_BANK, lit};
  endfunction

  // alias decode on a 12-bit address: returns hit, pointer index, kind
  function automatic logic [5:0] alias_dec(input logic [11:0] a);
    logic [7:0] rel;
    logic [7:0] lo;
    rel = 8'h00;
    lo = a[7:0];
    alias_dec = 6'h00;
    if (a[11:8] == SFR_BANK && lo <= ALIAS_BASE && lo >= 8'hd8) begin
      rel = ALIAS_BASE - lo;
      if (rel[2:0] <= OFS_INDIRECT && rel[4:3] != 2'b11) begin
        alias_dec = {1'b1, rel[4:3], rel[2:0]};
      end
    end
  endfunction

  // direct file address before alias resolution
  wire ilo_sel = extended_isa_enable_i && !instr_i.acc_bit
                 && instr_i.file_lit <= ILO_MAX;
  wire [11:0] ilo_addr = ptr_reg[2] + {4'h0, instr_i.file_lit};
  wire [11:0] direct_addr = instr_i.acc_bit
    ? {bank_select_reg_i, instr_i.file_lit}
    : access_map(instr_i.file_lit);
  wire is_file = instr_i.cls == DOAG_CLS_FILE;
  wire [11:0] file_addr = ilo_sel ? ilo_addr : direct_addr;
  wire [11:0] eff_base = (instr_i.cls == DOAG_CLS_MOVE)
    ? instr_i.src12 : file_addr;
  wire [5:0] adec = alias_dec(eff_base);
  wire alias_hit = instr_i.valid && (is_file
    || instr_i.cls == DOAG_CLS_MOVE) && adec[5];
  wire [1:0] asel = adec[4:3];
  wire [2:0] akind = adec[2:0];
  wire [11:0] sel_ptr = ptr_reg[asel];
  wire [11:0] wsext = {{4{wreg_i[7]}}, wreg_i};
  wire [11:0] ptr_inc = sel_ptr + 12'h001;
  wire [11:0] ptr_dec = sel_ptr - 12'h001;
  // indirect target per alias kind
  wire [11:0] ind_addr = (akind == OFS_PRE_INCREMENT_ALIAS) ? ptr_inc
    : (akind == OFS_POINTER_PLUS_WORKING_ALIAS) ? sel_ptr + wsext
    : sel_ptr;
  wire [11:0] op_addr = alias_hit ? ind_addr : eff_base;

  always_comb begin
    result_next = '0;
    result_next.valid = instr_i.valid;
    result_next.prog_target = instr_i.prog_lit;
    result_next.literal = instr_i.file_lit;
    result_next.addr = ADDR_RST;
    result_next.dst_addr = ADDR_RST;
    result_next.to_wreg = 1'b0;
    result_next.mode = DOAG_INHERENT;
    case (instr_i.cls)
      DOAG_CLS_INH: begin
        result_next.mode = DOAG_INHERENT;
        result_next.literal = 8'h00;
      end
      DOAG_CLS_LIT: begin
        result_next.mode = DOAG_LITERAL;
        result_next.to_wreg = 1'b1;
      end
      DOAG_CLS_FILE: begin
        result_next.mode = alias_hit ? DOAG_INDIRECT
          : ilo_sel ? DOAG_INDEXED : DOAG_DIRECT;
        result_next.addr = op_addr;
        result_next.dst_addr = op_addr;
        if (instr_i.has_dst) begin
          result_next.to_wreg = !instr_i.dst_bit;
        end else begin
          result_next.to_wreg = !instr_i.imp_to_reg;
        end
      end
      default: begin
        result_next.mode = DOAG_FULL12;
        result_next.addr = op_addr;
        result_next.dst_addr = instr_i.dst12;
      end
    endcase
  end

  // pointer update: a direct write wins for the byte it writes; the other byte keeps any alias step
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      ptr_next[i] = ptr_reg[i];
    end
    if (alias_hit) begin
      if (akind == OFS_POST_INCREMENT_ALIAS || akind == OFS_PRE_INCREMENT_ALIAS) begin
        ptr_next[asel] = ptr_inc;
      end else if (akind == OFS_POST_DECREMENT_ALIAS) begin
        ptr_next[asel] = ptr_dec;
      end
    end
    if (ptr_wr_i && ptr_wr_sel_i != 2'b11) begin
      if (ptr_wr_hi_i) begin
        ptr_next[ptr_wr_sel_i][11:8] = ptr_wr_data_i[3:0];
      end else begin
        ptr_next[ptr_wr_sel_i][7:0] = ptr_wr_data_i;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (int i = 0; i < 3; i++) begin
        ptr_reg[i] <= ADDR_RST;
      end
      result_reg <= '0;
      alias_hit_reg <= 1'b0;
    end else begin
      ptr_reg <= ptr_next;
      result_reg <= result_next;
      alias_hit_reg <= alias_hit;
    end
  end

  assign result_o = result_reg;
  assign ptr0_o = ptr_reg[0];
  assign ptr1_o = ptr_reg[1];
  assign ptr2_o = ptr_reg[2];
  assign alias_hit_o = alias_hit_reg;

  // assertions
  property p_ilo_off;
    @(posedge mclk_i) disable iff (!rstn_i)
    !extended_isa_enable_i |=> result_o.mode != DOAG_INDEXED;
  endproperty
  a_ilo_off: assert property (p_ilo_off) else $error("indexed mode without extension");
  property p_banked;
    @(posedge mclk_i) disable iff (!rstn_i)
    (instr_i.valid && is_file && instr_i.acc_bit && !alias_hit)
      |=> result_o.addr == $past({bank_select_reg_i, instr_i.file_lit});
  endproperty
  a_banked: assert property (p_banked) else $error("banked address wrong");
  property p_access;
    @(posedge mclk_i) disable iff (!rstn_i)
    (instr_i.valid && is_file && !instr_i.acc_bit && !ilo_sel && !alias_hit)
      |=> result_o.addr[11:8] == (result_o.addr[7:0] < ACCESS_SPLIT
          ? LOW_BANK : SFR_BANK);
  endproperty
  a_access: assert property (p_access) else $error("access map wrong");
  property p_move;
    @(posedge mclk_i) disable iff (!rstn_i)
    (instr_i.valid && instr_i.cls == DOAG_CLS_MOVE)
      |=> result_o.dst_addr == $past(instr_i.dst12);
  endproperty
  a_move: assert property (p_move) else $error("move dest wrong");
  property p_dst;
    @(posedge mclk_i) disable iff (!rstn_i)
    (instr_i.valid && is_file && instr_i.has_dst)
      |=> result_o.to_wreg == !$past(instr_i.dst_bit);
  endproperty
  a_dst: assert property (p_dst) else $error("destination steer wrong");
  property p_post_increment_alias;
    @(posedge mclk_i) disable iff (!rstn_i)
    (alias_hit && akind == OFS_POST_INCREMENT_ALIAS && asel == 2'd0 && !ptr_wr_i)
      |=> ptr0_o == $past(ptr0_o) + 12'h001;
  endproperty
  a_post_increment_alias: assert property (p_post_increment_alias) else $error("post increment wrong");
  property p_pointer_plus_working_alias;
    @(posedge mclk_i) disable iff (!rstn_i)
    (alias_hit && akind == OFS_POINTER_PLUS_WORKING_ALIAS && !ptr_wr_i)
      ##1 1'b1 |-> $stable(ptr0_o) && $stable(ptr1_o) && $stable(ptr2_o);
  endproperty
  a_pointer_plus_working_alias: assert property (p_pointer_plus_working_alias) else $error("plus working changed pointer");
  property p_ilo;
    @(posedge mclk_i) disable iff (!rstn_i)
    (instr_i.valid && is_file && ilo_sel && !alias_hit)
      |=> result_o.mode == DOAG_INDEXED
          && result_o.addr == $past(ptr2_o + {4'h0, instr_i.file_lit});
  endproperty
  a_ilo: assert property (p_ilo) else $error("indexed address wrong");
  property p_inh;
    @(posedge mclk_i) disable iff (!rstn_i)
    (instr_i.valid && instr_i.cls == DOAG_CLS_INH)
      |=> result_o.mode == DOAG_INHERENT && result_o.literal == 8'h00;
  endproperty
  a_inh: assert property (p_inh) else $error("inherent carried operand");
  property p_lit;
    @(posedge mclk_i) disable iff (!rstn_i)
    (instr_i.valid && instr_i.cls == DOAG_CLS_LIT)
      |=> result_o.mode == DOAG_LITERAL && result_o.to_wreg;
  endproperty
  a_lit: assert property (p_lit) else $error("literal mode wrong");
  property p_prog;
    @(posedge mclk_i) disable iff (!rstn_i)
    instr_i.valid
      |=> result_o.prog_target == $past(instr_i.prog_lit);
  endproperty
  a_prog: assert property (p_prog) else $error("program target wrong");
  property p_implicit;
    @(posedge mclk_i) disable iff (!rstn_i)
    (instr_i.valid && is_file && !instr_i.has_dst)
      |=> result_o.to_wreg == !$past(instr_i.imp_to_reg);
  endproperty
  a_implicit: assert property (p_implicit) else $error("implicit dest");
  property p_dst_w;
    @(posedge mclk_i) disable iff (!rstn_i)
    (instr_i.valid && is_file && instr_i.has_dst && !instr_i.dst_bit)
      |=> result_o.to_wreg;
  endproperty
  a_dst_w: assert property (p_dst_w) else $error("working dest wrong");
  property p_move_src;
    @(posedge mclk_i) disable iff (!rstn_i)
    (instr_i.valid && instr_i.cls == DOAG_CLS_MOVE && !alias_hit)
      |=> result_o.addr == $past(instr_i.src12);
  endproperty
  a_move_src: assert property (p_move_src) else $error("move source");
  property p_direct_mode;
    @(posedge mclk_i) disable iff (!rstn_i)
    (instr_i.valid && is_file && !ilo_sel && !alias_hit)
      |=> result_o.mode == DOAG_DIRECT;
  endproperty
  a_direct_mode: assert property (p_direct_mode) else $error("direct");
  property p_pre_increment_alias;
    @(posedge mclk_i) disable iff (!rstn_i)
    (alias_hit && akind == OFS_PRE_INCREMENT_ALIAS && asel == 2'd1 && !ptr_wr_i)
      |=> ptr1_o == $past(ptr1_o) + 12'h001 && result_o.addr == ptr1_o;
  endproperty
  a_pre_increment_alias: assert property (p_pre_increment_alias) else $error("pre increment wrong");
  property p_post_decrement_alias;
    @(posedge mclk_i) disable iff (!rstn_i)
    (alias_hit && akind == OFS_POST_DECREMENT_ALIAS && asel == 2'd0 && !ptr_wr_i)
      |=> ptr0_o == $past(ptr0_o) - 12'h001;
  endproperty
  a_post_decrement_alias: assert property (p_post_decrement_alias) else $error("post decrement");
  // plain indirect must not add anything to the pointer; only pointer 2 is checked for not moving
  property p_indirect;
    @(posedge mclk_i) disable iff (!rstn_i)
    (alias_hit && akind == OFS_INDIRECT && !ptr_wr_i)
      |=> result_o.addr == $past(sel_ptr) && $stable(ptr2_o);
  endproperty
  a_indirect: assert property (p_indirect) else $error("indirect wrong");
  property p_sel_refused;
    @(posedge mclk_i) disable iff (!rstn_i)
    (ptr_wr_i && ptr_wr_sel_i == 2'b11 && !alias_hit)
      |=> $stable(ptr0_o) && $stable(ptr1_o) && $stable(ptr2_o);
  endproperty
  a_sel_refused: assert property (p_sel_refused) else $error("sel 3");
  property p_ptr_hi;
    @(posedge mclk_i) disable iff (!rstn_i)
    (ptr_wr_i && ptr_wr_hi_i && ptr_wr_sel_i == 2'd0)
      |=> ptr0_o[11:8] == $past(ptr_wr_data_i[3:0]);
  endproperty
  a_ptr_hi: assert property (p_ptr_hi) else $error("pointer high byte");
  property p_hit;
    @(posedge mclk_i) disable iff (!rstn_i)
    alias_hit |=> alias_hit_o;
  endproperty
  a_hit: assert property (p_hit) else $error("alias hit lost");
  property p_mode_legal;
    @(posedge mclk_i) disable iff (!rstn_i)
    instr_i.valid |=> result_o.mode <= DOAG_FULL12;
  endproperty
  a_mode_legal: assert property (p_mode_legal) else $error("bad mode");
endmodule // doag_core

// *** logic/doag_pkg.sv ***
// package for the data operand address generator
package doag_pkg;
  localparam int ADDR_W = 12;
  localparam int BANK_W = 4;
  localparam logic [7:0] ACCESS_SPLIT = 8'h60;
  localparam logic [7:0] ILO_MAX = 8'h5f;
  localparam logic [3:0] SFR_BANK = 4'hf;
  localparam logic [3:0] LOW_BANK = 4'h0;
  localparam logic [11:0] ADDR_RST = 12'h000;
  localparam logic [7:0] WREG_RST = 8'h00;
  localparam logic [3:0] BSR_RST = 4'h0;
  // alias low-address codes within the sfr bank (per pointer, step 8)
  localparam logic [7:0] ALIAS_BASE = 8'hef;
  localparam logic [2:0] OFS_POINTER_PLUS_WORKING_ALIAS = 3'h0;
  localparam logic [2:0] OFS_PRE_INCREMENT_ALIAS = 3'h1;
  localparam logic [2:0] OFS_POST_DECREMENT_ALIAS = 3'h2;
  localparam logic [2:0] OFS_POST_INCREMENT_ALIAS = 3'h3;
  localparam logic [2:0] OFS_INDIRECT = 3'h4;
  localparam logic [2:0] OFS_PTR_LO = 3'h5;
  localparam logic [2:0] OFS_PTR_HI = 3'h6;

  typedef enum logic [2:0] {
    DOAG_INHERENT = 3'b000,
    DOAG_LITERAL = 3'b001,
    DOAG_DIRECT = 3'b010,
    DOAG_INDIRECT = 3'b011,
    DOAG_INDEXED = 3'b100,
    DOAG_FULL12 = 3'b101
  } doag_mode_e;

  typedef enum logic [1:0] {
    DOAG_CLS_INH = 2'b00,
    DOAG_CLS_LIT = 2'b01,
    DOAG_CLS_FILE = 2'b10,
    DOAG_CLS_MOVE = 2'b11
  } doag_cls_e;

  // decoded instruction fields from the decode stage
  typedef struct packed {
    logic valid;
    doag_cls_e cls;
    logic acc_bit;
    logic dst_bit;
    logic has_dst;
    logic imp_to_reg;
    logic [7:0] file_lit;
    logic [11:0] src12;
    logic [11:0] dst12;
    logic [19:0] prog_lit;
  } doag_instr_s;

  // address and steering result
  typedef struct packed {
    logic valid;
    doag_mode_e mode;
    logic [11:0] addr;
    logic [11:0] dst_addr;
    logic to_wreg;
    logic [19:0] prog_target;
    logic [7:0] literal;
  } doag_result_s;
endpackage

// *** verif/doag_dec_model.sv ***
// decode-stage partner: bank select and working register levels
`timescale 1ns/10ps
module doag_dec_model (
  input wire logic mclk_i,
  input wire logic ld_i,
  input wire logic [3:0] bank_d_i,
  input wire logic [7:0] w_d_i,
  output logic [3:0] bank_o,
  output logic [7:0] w_o
);
  // levels move only on a load, as the real registers do
  always_ff @(posedge mclk_i) begin
    if (ld_i) begin
      bank_o <= bank_d_i;
      w_o <= w_d_i;
    end
  end
endmodule // doag_dec_model

// *** verif/tb.sv ***
// testbench for the data operand address generator
`timescale 1ns/10ps
module tb;
  import doag_pkg::*;
  logic mclk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic xi = 1'b0;
  logic ld = 1'b0;
  logic [3:0] bank_d = 4'h0;
  logic [7:0] w_d = 8'h00;
  logic [3:0] bank;
  logic [7:0] w;
  logic pw = 1'b0;
  logic [1:0] psel = 2'h0;
  logic phi = 1'b0;
  logic [7:0] pdat = 8'h00;
  doag_instr_s instr_i = '0;
  doag_instr_s ins;
  doag_result_s res;
  logic [11:0] p0, p1, p2;
  logic hit;
  int err_total = 0;
  int cmp_count = 0;
  doag_dec_model pm_u (.mclk_i(mclk_i), .ld_i(ld), .bank_d_i(bank_d),
    .w_d_i(w_d), .bank_o(bank), .w_o(w));
  doag_core dut_u (.mclk_i(mclk_i), .rstn_i(rstn_i),
    .extended_isa_enable_i(xi), .instr_i(instr_i),
    .bank_select_reg_i(bank), .wreg_i(w), .ptr_wr_i(pw),
    .ptr_wr_sel_i(psel), .ptr_wr_hi_i(phi), .ptr_wr_data_i(pdat),
    .result_o(res), .ptr0_o(p0), .ptr1_o(p1), .ptr2_o(p2),
    .alias_hit_o(hit));
  initial begin
    forever #10 mclk_i = ~mclk_i;
  end
  task automatic chk(input logic [19:0] g, input logic [19:0] e);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // each driver lets one edge pass first so no strobe is set twice at once
  task automatic setr(input logic [3:0] b, input logic [7:0] v);
    @(negedge mclk_i);
    ld = 1'b1; bank_d = b; w_d = v;
    @(negedge mclk_i);
    ld = 1'b0;
  endtask
  task automatic wp(input logic [1:0] s, input logic h, input logic [7:0] d);
    @(negedge mclk_i);
    pw = 1'b1; psel = s; phi = h; pdat = d;
    @(negedge mclk_i);
    pw = 1'b0;
  endtask
  // one decoded instruction; result is settled at the next falling edge
  task automatic go(input doag_cls_e c, input logic a, input logic [7:0] f);
    @(negedge mclk_i);
    ins.cls = c; ins.acc_bit = a; ins.file_lit = f; ins.valid = 1'b1;
    instr_i = ins;
    @(negedge mclk_i);
    instr_i.valid = 1'b0;
  endtask
  task automatic t_direct();
    setr(4'h2, 8'h00);
    go(DOAG_CLS_FILE, 1'b1, 8'h20);
    chk(20'(res.addr), 20'h220);
    chk(20'(res.mode), 20'(DOAG_DIRECT));
    chk({19'h0, res.valid}, 20'h1);
    go(DOAG_CLS_FILE, 1'b0, 8'h5f);
    chk(20'(res.addr), 20'h05f);
    go(DOAG_CLS_FILE, 1'b0, 8'h60);
    chk(20'(res.addr), 20'hf60);
  endtask
  task automatic t_move();
    ins.src12 = 12'h123; ins.dst12 = 12'h456; setr(4'h5, 8'h00);
    go(DOAG_CLS_MOVE, 1'b1, 8'h00);
    chk(20'(res.addr), 20'h123);
    chk(20'(res.dst_addr), 20'h456);
  endtask
  task automatic t_dest();
    ins.has_dst = 1'b1; ins.dst_bit = 1'b1;
    go(DOAG_CLS_FILE, 1'b1, 8'h30);
    chk(20'(res.to_wreg), 20'h0);
    ins.dst_bit = 1'b0;
    go(DOAG_CLS_FILE, 1'b1, 8'h30);
    chk(20'(res.to_wreg), 20'h1);
    ins.has_dst = 1'b0; ins.imp_to_reg = 1'b1;
    go(DOAG_CLS_FILE, 1'b1, 8'h30);
    chk(20'(res.to_wreg), 20'h0);
  endtask
  task automatic t_lit();
    ins.prog_lit = 20'h9abcd;
    go(DOAG_CLS_LIT, 1'b0, 8'h7e);
    chk(res.prog_target, 20'h9abcd);
    chk(20'(res.literal), 20'h7e);
    go(DOAG_CLS_INH, 1'b0, 8'h7e);
    chk(20'(res.mode), 20'(DOAG_INHERENT));
    chk(20'(res.literal), 20'h0);
  endtask
  task automatic t_ptr();
    wp(2'h0, 1'b1, 8'hf0); wp(2'h0, 1'b0, 8'hff);
    go(DOAG_CLS_FILE, 1'b0, 8'hec);
    chk(20'(res.addr), 20'h0ff);
    chk({19'h0, hit}, 20'h1);
    chk(20'(p0), 20'h100);
    setr(4'h0, 8'hff);
    go(DOAG_CLS_FILE, 1'b0, 8'hef);
    chk(20'(res.addr), 20'h0ff);
    go(DOAG_CLS_FILE, 1'b0, 8'hed);
    chk(20'(p0), 20'h0ff);
    wp(2'h1, 1'b1, 8'h0f); wp(2'h1, 1'b0, 8'hff);
    go(DOAG_CLS_FILE, 1'b0, 8'he6);
    chk(20'(res.addr), 20'h000);
    chk(20'(p1), 20'h000);
    wp(2'h2, 1'b1, 8'h03); wp(2'h2, 1'b0, 8'h00);
    go(DOAG_CLS_FILE, 1'b0, 8'hdb);
    chk(20'(res.addr), 20'h300);
    chk(20'(p2), 20'h300);
    wp(2'h3, 1'b0, 8'h55);
    chk({8'h0, p0}, 20'h0ff);
    chk({8'h0, p2}, 20'h300);
  endtask
  task automatic t_index();
    go(DOAG_CLS_FILE, 1'b0, 8'h10);
    chk(20'(res.mode), 20'(DOAG_DIRECT));
    xi = 1'b1;
    go(DOAG_CLS_FILE, 1'b0, 8'h5f);
    chk(20'(res.addr), 20'h35f);
    chk(20'(res.mode), 20'(DOAG_INDEXED));
    go(DOAG_CLS_FILE, 1'b0, 8'h60);
    chk(20'(res.addr), 20'hf60);
    go(DOAG_CLS_FILE, 1'b1, 8'h10);
    chk(20'(res.addr), 20'h010);
    xi = 1'b0;
  endtask
  task automatic print_verdict();
    $display("compares=%0d errors=%0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    ins = '0;
    repeat (20) @(negedge mclk_i);
    rstn_i = 1'b1;
    t_direct();
    t_move();
    t_dest();
    t_lit();
    t_ptr();
    t_index();
    print_verdict();
  end
  // whole run is under 200 cycles; a hang stops long after
  initial begin
    #50us;
    err_total++;
    print_verdict();
  end
endmodule // tb
